// *** shared/cdp_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the cache data path
`ifndef CDP_REGS_VH
`define CDP_REGS_VH
// Word addresses of the special registers (compared against bus address bits 21:0)
`define CDP_MAINT_ADDR 22'h3fffe8
`define CDP_LTC_ADDR 22'h3fff66
`define CDP_MEM_SYSTEM_ERROR_REG_ADDR 22'h3fffd4
`define CDP_CCR_ADDR 22'h3fff84
// Output select codes
`define CDP_SEL_OFF 2'h0
`define CDP_SEL_ADDR 2'h1
`define CDP_SEL_MEM_SYSTEM_ERROR_REG 2'h2
`define CDP_SEL_FLUSH 2'h3
// Cache control field positions
`define CDP_CCR_WWTAG 10
`define CDP_CCR_FLUSH 8
`define CDP_CCR_PABORT 7
`define CDP_CCR_WWDATA 6
`define CDP_CCR_DIAG 1
`define CDP_CCR_NOINT 0
`define CDP_CCR_RESET 16'h0000
// Error register field positions
`define CDP_MEM_SYSTEM_ERROR_REG_ABORT 15
`define CDP_MEM_SYSTEM_ERROR_REG_HIGH 7
`define CDP_MEM_SYSTEM_ERROR_REG_LOW 6
`define CDP_MEM_SYSTEM_ERROR_REG_TAG 5
`define CDP_MEM_SYSTEM_ERROR_REG_RESET 16'h0000
// Special address space code
`define CDP_BS_IO 2'h3
// General-purpose write access code
`define CDP_AIO_GPWR 4'h1
// Bus reply timeout
`define CDP_TIMEOUT_NS 10000
`define CDP_CLK_NS 20
`define CDP_TIMEOUT_CYC (`CDP_TIMEOUT_NS / `CDP_CLK_NS)
`endif

// *** rtl/cdp_sync.v ***
// Three-stage input synchroniser with agreement filter on the last two stages
module cdp_sync #(
    parameter RST_VAL = 1'b1
) (
    input wire clk, // System clock
    input wire rst_b, // Asynchronous reset, active low
    input wire d_in, // Asynchronous input
    output reg q_out // Filtered synchronous level
);
    reg s1_reg; // First stage, read only by s2
    reg s2_reg; // Second stage
    reg s3_reg; // Third stage

    ////////////////////////////////////////////////////////////////////
    // Chain and agreement; output only moves when stages two and three agree
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q_out <= s3_reg;
            end
        end
    end
endmodule

// *** rtl/cdp_top.v ***
// Cache data path control: address, flush, tag parity and error logic
// Functional notes
// - Flag maintenance or line clock address
// - Select code picks driven register
// - Flush-step pulse advances flush counter
// - Flush-active high while cache flushes
// - Latch enable captures bank code, gates strobe
// - Strobe loads address; release clears, enables
// - Stretch enables abort, latches data; release clears
// - Address bits 21:13 form tag data
// - Update and check choose parity function
// - Predicted tag parity from address 21:13
// - Tag parity mismatch raises parity error
// - Memory parity bits 17,16 raise error
// - Byte parity errors set error bits
// - No reply in 10us aborts
// - Shadow cache control on processor write
// - Control bit 10 inverts tag parity
// - Control bit 8 starts flush, self-clears
// - Control bit 6 inverts data parity
// - Control bit 1 allocates on writes despite abort
// - Bits 7 and 0 choose error action
// - DMA address latched and driven out
// - 11-bit tag memory, miss input
// - 12-bit flush counter, overflow ends flush
// - Error register cleared by any write to it
`include "cdp_regs.vh"
module cdp_top #(
    parameter TIMEOUT_CYC = `CDP_TIMEOUT_CYC,
    parameter FLUSH_W = 12
) (
    input wire clk, // 50 MHz clock
    input wire rst_b, // Asynchronous reset, active low
    input wire ale_n, // Address latch enable, pin
    input wire addr_strobe_n, // Address strobe, pin
    input wire stretch_control_n, // Stretch control, pin
    input wire [1:0] bank_space_code, // Bank space code
    input wire [3:0] access_type_code, // Transaction type code
    input wire [21:0] muxed_addr_data_in, // Address/data bus input
    output reg [21:0] muxed_addr_data_out, // Address/data bus output
    output reg muxed_addr_data_oe, // Bus output enable, high when driving
    input wire [1:0] sel, // Output select from sequencer
    input wire flush_step, // Flush step from sequencer
    input wire update_n, // Tag update, active low
    input wire check, // Tag check
    input wire [10:0] tag_in, // Tag memory read data
    output reg [10:0] tag_out, // Tag memory write data
    output reg tag_oe, // Tag bus output enable
    output reg tag_cs_n, // Tag chip select
    input wire miss_n, // Cache miss from compare, active low
    input wire system_mem_parity_err, // Memory parity strobe
    input wire low_byte_parity_err, // Low byte data parity error
    input wire high_byte_parity_err, // High byte data parity error
    input wire bus_reply_in, // Bus reply
    input wire bus_read_strobe_out, // Module read strobe (sequencer)
    input wire bus_write_strobe_out, // Module write strobe (sequencer)
    input wire ccr_write, // Processor writes its cache control register
    input wire load_dma, // DMA latch load strobe
    input wire dma_oe_n, // DMA drive enable, active low
    input wire bypass, // Cache bypass indication
    input wire force_miss, // Cache force miss indication
    output reg special_addr_status, // Maintenance or line clock addressed
    output reg flush_active, // Flush in progress
    output reg predicted_tag_parity, // Predicted tag parity
    output reg wr_wrong_data_par, // Invert data byte parities
    output reg parity_error_n, // Parity error, active low
    output reg abort_n, // Abort, active low
    output reg gp_write_strobe_n, // General-purpose write strobe
    output reg allocate, // Allocate cache on this write
    output reg addr_bit0, // Address bit 0
    output reg [15:0] cache_control_reg, // Shadow control register
    output reg [21:0] dma_addr_out, // DMA address toward internal bus
    output reg dma_addr_oe // DMA drive enable
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire ale_s; // Synchronised latch enable
    wire strb_s; // Synchronised strobe
    wire sctl_s; // Synchronised stretch
    cdp_sync #(.RST_VAL(1'b1)) u_ale (.clk(clk), .rst_b(rst_b), .d_in(ale_n), .q_out(ale_s));
    cdp_sync #(.RST_VAL(1'b1)) u_strb (.clk(clk), .rst_b(rst_b), .d_in(addr_strobe_n), .q_out(strb_s));
    cdp_sync #(.RST_VAL(1'b1)) u_sctl (.clk(clk), .rst_b(rst_b), .d_in(stretch_control_n), .q_out(sctl_s));

    reg ale_d_reg; // Previous latch enable
    reg strb_d_reg; // Previous strobe
    reg sctl_d_reg; // Previous stretch
    wire ale_fall = ale_d_reg & ~ale_s; // Latch enable asserted
    wire strb_fall = strb_d_reg & ~strb_s; // Strobe asserted
    wire strb_rise = ~strb_d_reg & strb_s; // Strobe negated
    wire sctl_fall = sctl_d_reg & ~sctl_s; // Stretch asserted
    wire sctl_rise = ~sctl_d_reg & sctl_s; // Stretch negated

    ////////////////////////////////////////////////////////////////////
    // State
    reg [1:0] bs_reg; // Captured bank space
    reg [21:0] addr_reg; // Address register
    reg [21:0] wdata_reg; // Latched write data
    reg [15:0] mem_system_error_reg_reg; // Memory system error register
    reg [FLUSH_W-1:0] flush_cnt_reg; // Flush counter
    reg flush_ovf_reg; // Counter overflowed
    reg gp_en_reg; // General-purpose strobe enable
    reg abort_en_reg; // Abort output enable
    reg perr_latch_reg; // Parity error latch
    reg abort_latch_reg; // Abort latch
    reg [15:0] to_cnt_reg; // Reply timeout counter
    reg step_d_reg; // Previous flush step

    wire is_maint = (addr_reg == `CDP_MAINT_ADDR); // Maintenance addressed
    wire is_ltc = (addr_reg == `CDP_LTC_ADDR); // Line clock addressed
    wire [8:0] tag_field = addr_reg[21:13]; // Tag data
    wire tag_par = ^tag_field; // Even parity over tag
    wire do_update = ~update_n & ~check; // Generate and store
    wire do_check = update_n & check; // Check only
    wire tag_mismatch = do_check & (tag_in[9] != tag_par); // Stored vs predicted
    wire mem_err = system_mem_parity_err & (muxed_addr_data_in[17] | muxed_addr_data_in[16]);
    wire byte_err = low_byte_parity_err | high_byte_parity_err;
    wire any_err = mem_err | byte_err | tag_mismatch; // Any parity event
    wire strobe_out = bus_read_strobe_out | bus_write_strobe_out; // Reply awaited
    wire timeout = (to_cnt_reg == TIMEOUT_CYC[15:0]);
    wire step_rise = flush_step & ~step_d_reg; // One flush step

    ////////////////////////////////////////////////////////////////////
    // Strobe edge tracking
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ale_d_reg <= 1'b1;
            strb_d_reg <= 1'b1;
            sctl_d_reg <= 1'b1;
            step_d_reg <= 1'b0;
        end else begin
            ale_d_reg <= ale_s;
            strb_d_reg <= strb_s;
            sctl_d_reg <= sctl_s;
            step_d_reg <= flush_step;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address, bank code, write data and strobe enables
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bs_reg <= 2'h0;
            addr_reg <= 22'h000000;
            wdata_reg <= 22'h000000;
            gp_en_reg <= 1'b0;
            abort_en_reg <= 1'b0;
        end else begin
            if (ale_fall) begin
                bs_reg <= bank_space_code;
                gp_en_reg <= 1'b0; // Gate the strobe off
            end else if (strb_rise) begin
                gp_en_reg <= 1'b1;
            end
            if (strb_fall) begin
                addr_reg <= muxed_addr_data_in;
            end
            if (sctl_fall) begin
                abort_en_reg <= 1'b1;
                wdata_reg <= muxed_addr_data_in;
            end else if (sctl_rise) begin
                abort_en_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shadow control register; flush bit self-clears after overflow
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cache_control_reg <= `CDP_CCR_RESET;
        end else if (ccr_write && sctl_fall) begin
            cache_control_reg <= muxed_addr_data_in[15:0];
        end else if (flush_ovf_reg && sctl_s) begin
            cache_control_reg[`CDP_CCR_FLUSH] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flush counter: zeroed on stretch release while the flush bit is clear, stepped by sequencer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flush_cnt_reg <= {FLUSH_W{1'b0}};
            flush_ovf_reg <= 1'b0;
        end else if (sctl_rise && !cache_control_reg[`CDP_CCR_FLUSH]) begin
            flush_cnt_reg <= {FLUSH_W{1'b0}};
            flush_ovf_reg <= 1'b0;
        end else if (cache_control_reg[`CDP_CCR_FLUSH] && !flush_ovf_reg && step_rise) begin
            {flush_ovf_reg, flush_cnt_reg} <= {1'b0, flush_cnt_reg} + 1'b1;
        end else if (!cache_control_reg[`CDP_CCR_FLUSH]) begin
            flush_ovf_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reply timeout counter runs while a strobe waits for reply
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            to_cnt_reg <= 16'h0000;
        end else if (!strobe_out || bus_reply_in) begin
            to_cnt_reg <= 16'h0000;
        end else if (!timeout) begin
            to_cnt_reg <= to_cnt_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error register and latches; a new error wins over a clearing write
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_system_error_reg_reg <= `CDP_MEM_SYSTEM_ERROR_REG_RESET;
            perr_latch_reg <= 1'b0;
            abort_latch_reg <= 1'b0;
        end else begin
            if (strb_rise) begin
                perr_latch_reg <= 1'b0;
                abort_latch_reg <= 1'b0;
            end
            if (sctl_fall && ~access_type_code[0] && addr_reg == `CDP_MEM_SYSTEM_ERROR_REG_ADDR) begin
                mem_system_error_reg_reg <= 16'h0000; // Write clears all
            end
            if (any_err && !cache_control_reg[`CDP_CCR_PABORT] && cache_control_reg[`CDP_CCR_NOINT]) begin
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_HIGH] <= 1'b1; // Update only, still logged
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_LOW] <= 1'b1;
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_TAG] <= 1'b1;
            end else if (any_err && cache_control_reg[`CDP_CCR_PABORT]) begin
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_ABORT] <= 1'b1;
                if (high_byte_parity_err) mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_HIGH] <= 1'b1;
                if (low_byte_parity_err) mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_LOW] <= 1'b1;
                if (tag_mismatch) mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_TAG] <= 1'b1;
                abort_latch_reg <= 1'b1; // Abort through 114
                perr_latch_reg <= 1'b1;
            end else if (any_err) begin
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_HIGH] <= 1'b1; // All three when abort off
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_LOW] <= 1'b1;
                mem_system_error_reg_reg[`CDP_MEM_SYSTEM_ERROR_REG_TAG] <= 1'b1;
                perr_latch_reg <= 1'b1; // Interrupt through 114
            end
            if (timeout) begin
                abort_latch_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            muxed_addr_data_out <= 22'h000000;
            muxed_addr_data_oe <= 1'b0;
            tag_out <= 11'h000;
            tag_oe <= 1'b0;
            tag_cs_n <= 1'b1;
            special_addr_status <= 1'b0;
            flush_active <= 1'b0;
            predicted_tag_parity <= 1'b0;
            wr_wrong_data_par <= 1'b0;
            parity_error_n <= 1'b1;
            abort_n <= 1'b1;
            gp_write_strobe_n <= 1'b1;
            allocate <= 1'b0;
            addr_bit0 <= 1'b0;
            dma_addr_out <= 22'h000000;
            dma_addr_oe <= 1'b0;
        end else begin
            special_addr_status <= is_maint | is_ltc;
            muxed_addr_data_oe <= (sel != `CDP_SEL_OFF);
            if (sel == `CDP_SEL_ADDR) begin
                muxed_addr_data_out <= addr_reg;
            end else if (sel == `CDP_SEL_MEM_SYSTEM_ERROR_REG && is_ltc) begin
                muxed_addr_data_out <= 22'h000000; // Line clock register lives outside
            end else if (sel == `CDP_SEL_MEM_SYSTEM_ERROR_REG) begin
                muxed_addr_data_out <= {6'h00, mem_system_error_reg_reg};
            end else if (sel == `CDP_SEL_FLUSH) begin
                muxed_addr_data_out <= {addr_reg[21:13], flush_cnt_reg, 1'b0};
            end else begin
                muxed_addr_data_out <= 22'h000000;
            end
            flush_active <= cache_control_reg[`CDP_CCR_FLUSH] & ~flush_ovf_reg;
            predicted_tag_parity <= tag_par;
            tag_oe <= do_update;
            tag_cs_n <= ~(do_update | do_check); // 11-bit tag memory
            tag_out <= {tag_par ^ cache_control_reg[`CDP_CCR_WWTAG], 1'b1, tag_field};
            wr_wrong_data_par <= cache_control_reg[`CDP_CCR_WWDATA];
            parity_error_n <= ~perr_latch_reg;
            abort_n <= ~(abort_latch_reg & abort_en_reg);
            gp_write_strobe_n <= ~(gp_en_reg & (access_type_code == `CDP_AIO_GPWR));
            allocate <= ~access_type_code[0] & ~bypass & ~force_miss & ~miss_n
                & (cache_control_reg[`CDP_CCR_DIAG] | ~abort_latch_reg);
            addr_bit0 <= addr_reg[0];
            if (load_dma) begin
                dma_addr_out <= muxed_addr_data_in;
            end
            dma_addr_oe <= ~dma_oe_n;
        end
    end
endmodule

// *** test/cdp_seq_model.sv ***
// Behavioural sequencer and bus partner: flush stepping and bus reply
module cdp_seq_model (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic flush_active, // Flush request from the block
    input wire logic bus_read_strobe_out, // Module read strobe on the bus
    input wire logic slow, // Withhold the reply to force a timeout
    output logic flush_step, // One rising edge per flushed location
    output logic bus_reply_in // Bus reply toward the block
);
    logic [1:0] ph_reg; // Spacing between flush steps
    ////////////////////////////////////////////////////////////////
    // Step every fourth cycle so the block can drop flush_active before a spare step
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_reg <= 2'h0;
            flush_step <= 1'b0;
            bus_reply_in <= 1'b0;
        end else begin
            ph_reg <= flush_active ? ph_reg + 2'h1 : 2'h0;
            flush_step <= flush_active && ph_reg == 2'h3;
            bus_reply_in <= bus_read_strobe_out && !slow;
        end
    end
endmodule

// *** test/cdp_top_asserts.sv ***
// Port-level assertions for the cache data path control block
`include "cdp_regs.vh"
module cdp_chk (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic [1:0] sel, // Output select
    input wire logic [21:0] muxed_addr_data_in, // Bus input
    input wire logic [21:0] muxed_addr_data_out, // Bus output
    input wire logic muxed_addr_data_oe, // Bus drive enable
    input wire logic predicted_tag_parity, // Predicted parity
    input wire logic [15:0] cache_control_reg, // Control shadow
    input wire logic flush_active, // Flush in progress
    input wire logic load_dma, // DMA latch load
    input wire logic dma_oe_n, // DMA drive request
    input wire logic [21:0] dma_addr_out, // DMA address out
    input wire logic dma_addr_oe, // DMA drive enable
    input wire logic wr_wrong_data_par, // Data parity inversion
    input wire logic allocate, // Allocate on write
    input wire logic bypass, // Cache bypass
    input wire logic force_miss // Forced miss
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    property p_sel_off; sel == `CDP_SEL_OFF |=> !muxed_addr_data_oe; endproperty
    a_sel_off: assert property (p_sel_off) else $error("bus driven while deselected");
    property p_sel_on; sel != `CDP_SEL_OFF |=> muxed_addr_data_oe; endproperty
    a_sel_on: assert property (p_sel_on) else $error("bus not driven while selected");
    // Stable address so both outputs come from the same register contents
    property p_pred; $past(sel) == `CDP_SEL_ADDR && muxed_addr_data_oe && $stable(muxed_addr_data_out)
        |-> predicted_tag_parity == ^muxed_addr_data_out[21:13]; endproperty
    a_pred: assert property (p_pred) else $error("predicted parity wrong");
    property p_flush_go; $rose(cache_control_reg[8]) |=> flush_active; endproperty
    a_flush_go: assert property (p_flush_go) else $error("flush did not start");
    property p_flush_ccr; flush_active |-> cache_control_reg[8]; endproperty
    a_flush_ccr: assert property (p_flush_ccr) else $error("flush without control bit");
    property p_dma; load_dma ##1 (!load_dma && !dma_oe_n)
        |=> dma_addr_oe && dma_addr_out == $past(muxed_addr_data_in, 2); endproperty
    a_dma: assert property (p_dma) else $error("DMA address not driven");
    property p_wwd; $stable(cache_control_reg[6]) |-> wr_wrong_data_par == cache_control_reg[6]; endproperty
    a_wwd: assert property (p_wwd) else $error("data parity inversion wrong");
    property p_alloc; allocate |-> !$past(bypass) && !$past(force_miss); endproperty
    a_alloc: assert property (p_alloc) else $error("allocate while bypassing");
endmodule
bind cdp_top cdp_chk u_chk (.*);

// *** test/cdp_top_bench.sv ***
// Self-checking bench for the cache data path control block
`include "cdp_regs.vh"
module cdp_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [21:0] ADR = 22'h15a3c4; // Plain cacheable address
    localparam int FW = 4; // Short flush counter keeps the run brief
    logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0; // Clock, reset, reply withheld
    logic ale_n = 1'b1, addr_strobe_n = 1'b1, stretch_control_n = 1'b1; // Processor strobes
    logic [1:0] bank_space_code = 2'h0, sel = 2'h0; // Space code, output select
    logic [3:0] access_type_code = 4'h0; // Transfer type
    logic [21:0] muxed_addr_data_in = 22'h0; // Address and data in
    logic update_n = 1'b1, check = 1'b0, miss_n = 1'b1; // Tag control, miss
    logic [10:0] tag_in = 11'h0; // Tag memory read data
    logic system_mem_parity_err = 1'b0, low_byte_parity_err = 1'b0, high_byte_parity_err = 1'b0;
    logic bus_read_strobe_out = 1'b0, bus_write_strobe_out = 1'b0, ccr_write = 1'b0; // Strobes
    logic load_dma = 1'b0, dma_oe_n = 1'b1, bypass = 1'b0, force_miss = 1'b0; // DMA and cache modes
    logic [21:0] muxed_addr_data_out, dma_addr_out; // Bus and DMA outputs
    logic [10:0] tag_out; // Tag write data
    logic [15:0] cache_control_reg; // Shadow control
    logic muxed_addr_data_oe, tag_oe, tag_cs_n, special_addr_status, flush_active, flush_step;
    logic predicted_tag_parity, wr_wrong_data_par, parity_error_n, abort_n, gp_write_strobe_n;
    logic allocate, addr_bit0, dma_addr_oe, bus_reply_in, fs_q = 1'b0; // Misc outputs
    int n_fail = 0, samples_checked = 0, n_steps = 0; // Counters
    cdp_top #(.TIMEOUT_CYC(20), .FLUSH_W(FW)) DUT (.*);
    cdp_seq_model MDL (.*);
    always #10 clk = ~clk;
    // Count flush steps on their rising edges
    always @(posedge clk) begin
        fs_q <= flush_step;
        if (flush_step && !fs_q) n_steps++;
    end
    ////////////////////////////////////////////////////////////////
    task tick(input int n); repeat (n) @(posedge clk); #2; endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes are synchronised inside, so each phase is held eight cycles
    task start(input logic [21:0] a, input logic [3:0] k);
        muxed_addr_data_in = a; access_type_code = k; ale_n = 0; tick(8);
        addr_strobe_n = 0; tick(8);
    endtask
    task data(input logic [21:0] d); muxed_addr_data_in = d; stretch_control_n = 0; tick(8); endtask
    task fin; stretch_control_n = 1; tick(8); addr_strobe_n = 1; ale_n = 1; tick(8); endtask
    task wccr(input logic [15:0] v);
        start(`CDP_CCR_ADDR, 4'h0); ccr_write = 1; data({6'h0, v}); ccr_write = 0; fin;
    endtask
    task test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_sas;
        logic [21:0] a[3];
        a = '{ADR, `CDP_MAINT_ADDR, `CDP_LTC_ADDR};
        for (int i = 0; i < 3; i++) begin
            start(a[i], 4'h1); chk(special_addr_status, i != 0); data(0); fin;
        end
    endtask
    task t_sel;
        start(ADR, 4'h1); sel = `CDP_SEL_ADDR; tick(2);
        chk(gp_write_strobe_n, 1);
        chk(muxed_addr_data_out, ADR);
        chk(predicted_tag_parity, ^ADR[21:13]);
        update_n = 0; tick(2); chk(tag_out[8:0], ADR[21:13]);
        chk({tag_oe, tag_cs_n}, 2'b10);
        update_n = 1; sel = `CDP_SEL_MEM_SYSTEM_ERROR_REG; tick(2); chk(muxed_addr_data_out, 0);
        sel = `CDP_SEL_FLUSH; tick(2); chk(muxed_addr_data_oe, 1);
        sel = `CDP_SEL_OFF; tick(2); chk(muxed_addr_data_oe, 0);
        data(0); fin;
        chk(gp_write_strobe_n, 0);
    endtask
    // Stored parity bit deliberately wrong; the undefined mode must stay quiet
    task t_tag;
        start(ADR, 4'h1); tag_in = {1'b1, ~(^ADR[21:13]), ADR[21:13]};
        check = 1; update_n = 0; tick(4); chk(parity_error_n, 1);
        update_n = 1; tick(4); chk(parity_error_n, 0);
        check = 0; data(0); fin; chk(parity_error_n, 1);
    endtask
    task t_ccr;
        logic [10:0] t0;
        start(ADR, 4'h0); update_n = 0; tick(2); t0 = tag_out; update_n = 1; data(0); fin;
        wccr(16'h04c3); chk(cache_control_reg & 16'h05c3, 16'h04c3);
        chk(wr_wrong_data_par, 1);
        start(ADR, 4'h0); update_n = 0; tick(2); chk(tag_out ^ t0, 11'h400);
        update_n = 1; miss_n = 0; data(0); chk(allocate, 1);
        bypass = 1; tick(2); chk(allocate, 0);
        bypass = 0; miss_n = 1; fin; wccr(16'h0000); chk(wr_wrong_data_par, 0);
    endtask
    task t_err;
        start(ADR, 4'h1); system_mem_parity_err = 1; data(22'h020000);
        chk({abort_n, parity_error_n}, 2'b10);
        system_mem_parity_err = 0; fin; wccr(16'h0080);
        start(ADR, 4'h1); low_byte_parity_err = 1; data(0);
        chk({abort_n, parity_error_n}, 2'b00);
        low_byte_parity_err = 0; fin;
        sel = `CDP_SEL_MEM_SYSTEM_ERROR_REG; tick(2); chk(muxed_addr_data_out[6], 1);
        sel = `CDP_SEL_OFF; start(`CDP_MEM_SYSTEM_ERROR_REG_ADDR, 4'h0); data(0); fin;
        sel = `CDP_SEL_MEM_SYSTEM_ERROR_REG; tick(2); chk(muxed_addr_data_out[7:5], 0);
        sel = `CDP_SEL_OFF; wccr(16'h0000);
    endtask
    task t_tout;
        int i;
        start(ADR, 4'h1); data(0); slow = 1; bus_read_strobe_out = 1; i = 0;
        while (abort_n !== 1'b0 && i < 60) begin tick(1); i++; end
        if (i >= 60) begin n_fail++; test_done; end
        chk(i >= 19 && i <= 27, 1);
        bus_read_strobe_out = 0; slow = 0; fin;
        start(ADR, 4'h1); data(0); bus_read_strobe_out = 1; tick(40);
        chk(abort_n, 1);
        bus_read_strobe_out = 0; fin;
    endtask
    task t_flush;
        int i;
        n_steps = 0; start(`CDP_CCR_ADDR, 4'h0); ccr_write = 1; data({6'h0, 16'h0100}); ccr_write = 0;
        chk(flush_active, 1); i = 0;
        while (flush_active !== 1'b0 && i < 400) begin tick(1); i++; end
        if (i >= 400) begin n_fail++; test_done; end
        chk(n_steps, 1 << FW);
        chk(cache_control_reg[8], 1); fin; chk(cache_control_reg[8], 0);
    endtask
    task t_dma;
        muxed_addr_data_in = 22'h2bcd12; load_dma = 1; tick(1); load_dma = 0;
        muxed_addr_data_in = 22'h0; dma_oe_n = 0; tick(2);
        chk({dma_addr_oe, dma_addr_out}, {1'b1, 22'h2bcd12});
        dma_oe_n = 1; tick(2); chk(dma_addr_oe, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1;
        tick(6);
        t_sas; t_sel; t_tag; t_ccr; t_err; t_tout; t_flush; t_dma;
        test_done;
    end
endmodule
